// [verilog/acr_regs.sv]
// Converter result, charger control and USB control register bank
//
// How it works
// RULE1: Result word bits 2..11 show first channel result, read-only.
// RULE2: Result word bits 14..23 show second channel result, read-only.
// RULE3: Charger bits 0..2 select charge voltage, reset to 3'b011.
// RULE4: Charger bits 3..6 hold current DAC; software or device may change.
// RULE5: Charger bit 7 enables trickle current, resets to zero.
// RULE6: Charger bit 8 acknowledges low power boot, read/write, resets zero.
// RULE7: Charger bit 9 disables thermistor check, resets zero.
// RULE8: Writing one to charger bit 20 restarts charger; device clears it.
// RULE9: Charger bit 21 blocks automatic charging while on, resets zero.
// RULE10: Charger bit 23 allows software voltage and current programming.
// RULE11: USB bit 22 selects ID pin pull-up source, resets zero.
// RULE12: Unused, reserved and read-only spare bits read zero, ignore writes; charger bits 10..13, 15..19 and USB bit 6 (reset one) are writable.
`timescale 1ns/1ps
module acr_regs #(
    parameter logic [2:0] GEN_CODE = 3'h2 // Arbitrary value
) (
    // Clock and reset
    input wire logic MCLK_IN,
    input wire logic ARST_N_IN,
    // Register access port
    input wire logic [5:0] REG_ADDR_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [23:0] REG_WDATA_IN,
    output logic [23:0] REG_RDATA_OUT,
    output logic REG_RVALID_OUT,
    // Second converter results
    input wire logic SCONV_LOAD_IN,
    input wire logic [9:0] SCONV_RES1_IN,
    input wire logic [9:0] SCONV_RES2_IN,
    // Charger side inputs
    input wire logic CHG_DAC_LOAD_IN,
    input wire logic [3:0] CHG_DAC_VAL_IN,
    input wire logic CHG_RESTART_DONE_IN,
    // Charger controls
    output logic [2:0] CHARGE_VOLT_SEL_OUT,
    output logic [3:0] CHARGE_CURRENT_DAC_OUT,
    output logic TRICKLE_ENABLE_OUT,
    output logic LOW_POWER_BOOT_ACK_OUT,
    output logic THERMISTOR_CHECK_OFF_OUT,
    output logic CHARGER_FSM_RESTART_OUT,
    output logic AUTO_CHARGE_BLOCK_OUT,
    output logic CYCLING_DISABLE_OUT,
    output logic VI_PROGRAM_ALLOW_OUT,
    output logic [23:0] CHG_CTRL_OUT,
    // USB control
    output logic ID_PULLUP_SOURCE_SEL_OUT
);
    acr_wr_if acc ();

    logic [23:0] chg_d;
    logic [23:0] chg_q;
    logic [23:0] usb_d;
    logic [23:0] usb_q;
    logic [23:0] rdata_d;
    logic [23:0] rdata_q;
    logic rvalid_d;
    logic rvalid_q;
    logic [2*acr_pkg::RES_W-1:0] res;
    logic wr_chg;
    logic wr_usb;

    acr_addr_dec u_dec (
        .addr_in(REG_ADDR_IN),
        .wr_in(REG_WR_IN),
        .rd_in(REG_RD_IN),
        .wdata_in(REG_WDATA_IN),
        .acc(acc)
    );

    acr_result_latch #(
        .RES_W(acr_pkg::RES_W),
        .NCH(2)
    ) u_res (
        .clk_in(MCLK_IN),
        .rst_n_in(ARST_N_IN),
        .load_in(SCONV_LOAD_IN),
        .res_in({SCONV_RES2_IN, SCONV_RES1_IN}),
        .res_out(res)
    );

    assign wr_chg = acc.wr & acc.sel[acr_pkg::SEL_CHG];
    assign wr_usb = acc.wr & acc.sel[acr_pkg::SEL_USB];

    // Charger control word next value
    always_comb begin
        chg_d = chg_q;
        if (wr_chg) begin
            // Plain read/write bits
            chg_d = (chg_q & ~acr_pkg::CHG_RW_MASK) |
                    (acc.wdata & acr_pkg::CHG_RW_MASK); // RULE5 RULE6 RULE7 RULE9
            // Voltage and current only when the written word sets bit 23
            if (acc.wdata[acr_pkg::VI_ALLOW_BIT]) begin // RULE10
                chg_d[acr_pkg::VOLT_LSB +: acr_pkg::VOLT_W] =
                    acc.wdata[acr_pkg::VOLT_LSB +: acr_pkg::VOLT_W]; // RULE3
                chg_d[acr_pkg::DAC_LSB +: acr_pkg::DAC_W] =
                    acc.wdata[acr_pkg::DAC_LSB +: acr_pkg::DAC_W]; // RULE4
            end
        end
        // Device update of the current DAC wins over software
        if (CHG_DAC_LOAD_IN) begin
            chg_d[acr_pkg::DAC_LSB +: acr_pkg::DAC_W] = CHG_DAC_VAL_IN; // RULE4
        end
        // Software set wins over device clear
        if (wr_chg && acc.wdata[acr_pkg::RESTART_BIT]) begin
            chg_d[acr_pkg::RESTART_BIT] = 1'b1; // RULE8
        end else if (CHG_RESTART_DONE_IN) begin
            chg_d[acr_pkg::RESTART_BIT] = 1'b0; // RULE8
        end
        chg_d = chg_d & acr_pkg::CHG_IMPL_MASK; // RULE12
    end

    // USB control word next value
    always_comb begin
        usb_d = usb_q;
        if (wr_usb) begin
            usb_d = acc.wdata & acr_pkg::USB_RW_MASK; // RULE11 RULE12
        end
    end

    // Read data, one cycle after the strobe
    always_comb begin
        rdata_d = rdata_q;
        rvalid_d = acc.rd;
        if (acc.rd) begin
            rdata_d = '0; // RULE12
            if (acc.sel[acr_pkg::SEL_GEN_ID]) begin
                rdata_d[acr_pkg::GEN_LSB +: acr_pkg::GEN_W] = GEN_CODE;
            end else if (acc.sel[acr_pkg::SEL_SCONV]) begin
                rdata_d[acr_pkg::RES1_LSB +: acr_pkg::RES_W] =
                    res[0 +: acr_pkg::RES_W]; // RULE1
                rdata_d[acr_pkg::RES2_LSB +: acr_pkg::RES_W] =
                    res[acr_pkg::RES_W +: acr_pkg::RES_W]; // RULE2
            end else if (acc.sel[acr_pkg::SEL_CHG]) begin
                rdata_d = chg_q;
            end else if (acc.sel[acr_pkg::SEL_USB]) begin
                rdata_d = usb_q;
            end
        end
    end

    always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            chg_q <= acr_pkg::CHG_RST; // RULE3
            usb_q <= acr_pkg::USB_RST; // RULE11
            rdata_q <= 24'h000000;
            rvalid_q <= 1'b0;
        end else begin
            chg_q <= chg_d;
            usb_q <= usb_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign REG_RDATA_OUT = rdata_q;
    assign REG_RVALID_OUT = rvalid_q;
    assign CHARGE_VOLT_SEL_OUT = chg_q[acr_pkg::VOLT_LSB +: acr_pkg::VOLT_W];
    assign CHARGE_CURRENT_DAC_OUT = chg_q[acr_pkg::DAC_LSB +: acr_pkg::DAC_W];
    assign TRICKLE_ENABLE_OUT = chg_q[acr_pkg::TRICKLE_BIT];
    assign LOW_POWER_BOOT_ACK_OUT = chg_q[acr_pkg::LPB_ACK_BIT];
    assign THERMISTOR_CHECK_OFF_OUT = chg_q[acr_pkg::THERM_OFF_BIT];
    assign CHARGER_FSM_RESTART_OUT = chg_q[acr_pkg::RESTART_BIT];
    assign AUTO_CHARGE_BLOCK_OUT = chg_q[acr_pkg::AUTO_BLOCK_BIT];
    assign CYCLING_DISABLE_OUT = chg_q[acr_pkg::CYCLE_OFF_BIT];
    assign VI_PROGRAM_ALLOW_OUT = chg_q[acr_pkg::VI_ALLOW_BIT];
    assign CHG_CTRL_OUT = chg_q;
    assign ID_PULLUP_SOURCE_SEL_OUT = usb_q[acr_pkg::IDPU_BIT];
endmodule : acr_regs

// [verilog/acr_pkg.sv]
// Shared offsets, field positions and reset values of the register bank
package acr_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 24;
    localparam int NREG = 4;
    localparam int RES_W = 10;
    // Register offsets
    localparam logic [5:0] OFS_GEN_ID = 6'h2E;
    localparam logic [5:0] OFS_SCONV = 6'h2F;
    localparam logic [5:0] OFS_CHG = 6'h30;
    localparam logic [5:0] OFS_USB = 6'h31;
    // One-hot select positions
    localparam int SEL_GEN_ID = 0;
    localparam int SEL_SCONV = 1;
    localparam int SEL_CHG = 2;
    localparam int SEL_USB = 3;
    // Generation word
    localparam int GEN_LSB = 6;
    localparam int GEN_W = 3;
    // Second converter result word
    localparam int RES1_LSB = 2;
    localparam int RES2_LSB = 14;
    // Charger control fields
    localparam int VOLT_LSB = 0;
    localparam int VOLT_W = 3;
    localparam int DAC_LSB = 3;
    localparam int DAC_W = 4;
    localparam int TRICKLE_BIT = 7;
    localparam int LPB_ACK_BIT = 8;
    localparam int THERM_OFF_BIT = 9;
    localparam int RESTART_BIT = 20;
    localparam int AUTO_BLOCK_BIT = 21;
    localparam int CYCLE_OFF_BIT = 22;
    localparam int VI_ALLOW_BIT = 23;
    localparam logic [2:0] VOLT_RST = 3'h3;
    localparam logic [23:0] CHG_RST = 24'h400003;
    // Plain read/write bits, written directly by software
    localparam logic [23:0] CHG_RW_MASK = 24'hEFBF80;
    // Every bit that has storage; the rest read zero
    localparam logic [23:0] CHG_IMPL_MASK = 24'hFFBFFF;
    // USB control word
    localparam int IDPU_BIT = 22;
    localparam logic [23:0] USB_RW_MASK = 24'h400040;
    localparam logic [23:0] USB_RST = 24'h000040;
endpackage : acr_pkg

// [verilog/acr_wr_if.sv]
// Decoded register access carried from the decoder to the bank
`timescale 1ns/1ps
interface acr_wr_if;
    logic [acr_pkg::NREG-1:0] sel;
    logic wr;
    logic rd;
    logic [acr_pkg::DATA_W-1:0] wdata;
    modport dec (output sel, output wr, output rd, output wdata);
    modport bank (input sel, input wr, input rd, input wdata);
endinterface : acr_wr_if

// [verilog/acr_addr_dec.sv]
// Register address decoder producing one-hot selects
`timescale 1ns/1ps
module acr_addr_dec (
    // Access request
    input wire logic [acr_pkg::ADDR_W-1:0] addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [acr_pkg::DATA_W-1:0] wdata_in,
    // Decoded access
    acr_wr_if.dec acc
);
    function automatic logic [acr_pkg::NREG-1:0] decode(
        input logic [acr_pkg::ADDR_W-1:0] a);
        logic [acr_pkg::NREG-1:0] s;
        s = '0;
        if (a == acr_pkg::OFS_GEN_ID) begin
            s[acr_pkg::SEL_GEN_ID] = 1'b1;
        end else if (a == acr_pkg::OFS_SCONV) begin
            s[acr_pkg::SEL_SCONV] = 1'b1;
        end else if (a == acr_pkg::OFS_CHG) begin
            s[acr_pkg::SEL_CHG] = 1'b1;
        end else if (a == acr_pkg::OFS_USB) begin
            s[acr_pkg::SEL_USB] = 1'b1;
        end
        return s;
    endfunction : decode

    always_comb begin
        acc.sel = decode(addr_in);
        acc.wr = wr_in;
        acc.rd = rd_in;
        acc.wdata = wdata_in;
    end
endmodule : acr_addr_dec

// [verilog/acr_result_latch.sv]
// Holds the two second-converter channel results
`timescale 1ns/1ps
module acr_result_latch #(
    parameter int RES_W = 10,
    parameter int NCH = 2
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Results from the converter
    input wire logic load_in,
    input wire logic [NCH*RES_W-1:0] res_in,
    // Held results
    output logic [NCH*RES_W-1:0] res_out
);
    logic [NCH*RES_W-1:0] res_d;
    logic [NCH*RES_W-1:0] res_q;

    // Refuse sizes the slicing below cannot serve
    if (RES_W < 1 || NCH < 1) begin : g_bad_param
        $error("acr_result_latch: RES_W and NCH must be positive");
    end

    generate
        for (genvar i = 0; i < NCH; i++) begin : g_ch
            always_comb begin
                res_d[i*RES_W +: RES_W] = res_q[i*RES_W +: RES_W];
                if (load_in) begin
                    res_d[i*RES_W +: RES_W] = res_in[i*RES_W +: RES_W];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            res_q <= '0;
        end else begin
            res_q <= res_d;
        end
    end

    assign res_out = res_q;
endmodule : acr_result_latch

// [verification/acr_regs_assertions.sv]
// Port-level assertions for the register bank
`timescale 1ns/1ps
module acr_regs_chk (
    // Clock, reset and register port
    input wire logic MCLK_IN,
    input wire logic ARST_N_IN,
    input wire logic [5:0] REG_ADDR_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [23:0] REG_WDATA_IN,
    input wire logic [23:0] REG_RDATA_OUT,
    // Charger and USB side
    input wire logic CHG_DAC_LOAD_IN,
    input wire logic [3:0] CHG_DAC_VAL_IN,
    input wire logic [2:0] CHARGE_VOLT_SEL_OUT,
    input wire logic [3:0] CHARGE_CURRENT_DAC_OUT,
    input wire logic CHARGER_FSM_RESTART_OUT,
    input wire logic [23:0] CHG_CTRL_OUT,
    input wire logic ID_PULLUP_SOURCE_SEL_OUT
);
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (!ARST_N_IN);
    logic wc;
    assign wc = REG_WR_IN && REG_ADDR_IN == 6'h30;
    property p_volt;
        !(wc && REG_WDATA_IN[23]) |=> $stable(CHARGE_VOLT_SEL_OUT);
    endproperty
    a_volt: assert property (p_volt) else $error("volt moved");
    property p_dac;
        CHG_DAC_LOAD_IN |=> CHARGE_CURRENT_DAC_OUT == $past(CHG_DAC_VAL_IN);
    endproperty
    a_dac: assert property (p_dac) else $error("dac load lost");
    property p_bits;
        wc |=> CHG_CTRL_OUT[9:7] == $past(REG_WDATA_IN[9:7])
            && CHG_CTRL_OUT[23:21] == $past(REG_WDATA_IN[23:21]);
    endproperty
    a_bits: assert property (p_bits) else $error("ctl bit");
    property p_rst;
        wc && REG_WDATA_IN[20] |=> CHARGER_FSM_RESTART_OUT;
    endproperty
    a_rst: assert property (p_rst) else $error("no restart");
    property p_idpu;
        REG_WR_IN && REG_ADDR_IN == 6'h31
        |=> ID_PULLUP_SOURCE_SEL_OUT == $past(REG_WDATA_IN[22]);
    endproperty
    a_idpu: assert property (p_idpu) else $error("id pullup");
    property p_gen;
        REG_RD_IN && REG_ADDR_IN == 6'h2E
        |=> REG_RDATA_OUT[5:0] == 6'h00 && REG_RDATA_OUT[23:9] == 15'h0000;
    endproperty
    a_gen: assert property (p_gen) else $error("gen spare");
    property p_usb;
        REG_RD_IN && REG_ADDR_IN == 6'h31
        |=> (REG_RDATA_OUT & 24'hBFFFBF) == 24'h000000;
    endproperty
    a_usb: assert property (p_usb) else $error("usb spare");
    property p_b14;
        wc |=> (CHG_CTRL_OUT[14] == 1'b0) [*2];
    endproperty
    a_b14: assert property (p_b14) else $error("bit 14");
endmodule : acr_regs_chk

bind acr_regs acr_regs_chk chk_u (.MCLK_IN(MCLK_IN), .ARST_N_IN(ARST_N_IN),
    .REG_ADDR_IN(REG_ADDR_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
    .REG_WDATA_IN(REG_WDATA_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
    .CHG_DAC_LOAD_IN(CHG_DAC_LOAD_IN), .CHG_DAC_VAL_IN(CHG_DAC_VAL_IN),
    .CHARGE_VOLT_SEL_OUT(CHARGE_VOLT_SEL_OUT),
    .CHARGE_CURRENT_DAC_OUT(CHARGE_CURRENT_DAC_OUT),
    .CHARGER_FSM_RESTART_OUT(CHARGER_FSM_RESTART_OUT),
    .CHG_CTRL_OUT(CHG_CTRL_OUT),
    .ID_PULLUP_SOURCE_SEL_OUT(ID_PULLUP_SOURCE_SEL_OUT));

// [verification/acr_host_model.sv]
// Processor-side model issuing register reads and writes
`timescale 1ns/1ps
module acr_host_model (
    input wire logic clk_in,
    output logic [5:0] addr_out,
    output logic wr_out,
    output logic rd_out,
    output logic [23:0] wdata_out
);
    initial begin
        addr_out = 6'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = 24'h000000;
    end
    task automatic access(input logic w, input logic [5:0] a,
        input logic [23:0] d);
        @(negedge clk_in);
        addr_out = a;
        wdata_out = d;
        wr_out = w;
        rd_out = !w;
        @(negedge clk_in);
        wr_out = 1'b0;
        rd_out = 1'b0;
        // Released bus shows the inverse, never the old word
        addr_out = ~a;
        wdata_out = ~d;
    endtask : access
endmodule : acr_host_model

// [verification/test_acr_regs.sv]
// Self-checking bench for the register bank
`timescale 1ns/1ps
module test_acr_regs;
    localparam logic [2:0] GEN = 3'h5; // Arbitrary value
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr, rd, rv;
    logic sload = 1'b0, dload = 1'b0, done = 1'b0;
    logic [5:0] addr;
    logic [23:0] wd, rdat, d;
    logic [9:0] r1 = 10'h000, r2 = 10'h000;
    logic [3:0] dval = 4'h0;
    logic [23:0] chg_m = 24'h400003;
    logic [23:0] exp_q[$];
    logic [2:0] volt;
    logic [3:0] dac;
    logic [23:0] ctl;
    logic trk, lpb, therm, fsm, ablk, cyc, vi, idpu;
    logic idpu_m = 1'b0;
    int failures = 0, samples_checked = 0, cycles = 0;
    acr_host_model host_u (.clk_in(clk), .addr_out(addr), .wr_out(wr),
        .rd_out(rd), .wdata_out(wd));
    acr_regs #(.GEN_CODE(GEN)) dut_u (.MCLK_IN(clk), .ARST_N_IN(rst_n),
        .REG_ADDR_IN(addr), .REG_WR_IN(wr), .REG_RD_IN(rd),
        .REG_WDATA_IN(wd), .REG_RDATA_OUT(rdat), .REG_RVALID_OUT(rv),
        .SCONV_LOAD_IN(sload), .SCONV_RES1_IN(r1), .SCONV_RES2_IN(r2),
        .CHG_DAC_LOAD_IN(dload), .CHG_DAC_VAL_IN(dval),
        .CHG_RESTART_DONE_IN(done), .CHARGE_VOLT_SEL_OUT(volt),
        .CHARGE_CURRENT_DAC_OUT(dac), .TRICKLE_ENABLE_OUT(trk),
        .LOW_POWER_BOOT_ACK_OUT(lpb), .THERMISTOR_CHECK_OFF_OUT(therm),
        .CHARGER_FSM_RESTART_OUT(fsm), .AUTO_CHARGE_BLOCK_OUT(ablk),
        .CYCLING_DISABLE_OUT(cyc), .VI_PROGRAM_ALLOW_OUT(vi),
        .CHG_CTRL_OUT(ctl), .ID_PULLUP_SOURCE_SEL_OUT(idpu));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic give_verdict;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0 && exp_q.size() == 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict
    task automatic rd_chk(input logic [5:0] a, input logic [23:0] e);
        exp_q.push_back(e);
        host_u.access(1'b0, a, 24'h000000);
    endtask : rd_chk
    // Level outputs against the modelled control words
    task automatic out_chk;
        samples_checked++;
        if ({vi, cyc, ablk, fsm, therm, lpb, trk, dac, volt} !==
            {chg_m[23:20], chg_m[9:0]} || ctl !== chg_m ||
            idpu !== idpu_m) begin
            failures++;
            $display("MISMATCH %0t control outputs %h", $time, ctl);
        end
    endtask : out_chk
    task automatic wr_chg(input logic [23:0] v);
        host_u.access(1'b1, 6'h30, v);
        chg_m = (chg_m & ~acr_pkg::CHG_RW_MASK) | (v & acr_pkg::CHG_RW_MASK);
        if (v[23]) chg_m[6:0] = v[6:0];
        if (v[20]) chg_m[20] = 1'b1;
    endtask : wr_chg
    // Outputs settle after the rising edge; look at the falling one
    always @(negedge clk) begin
        cycles++;
        if (rv === 1'b1) begin
            samples_checked++;
            if (exp_q.size() == 0 || rdat !== exp_q.pop_front()) begin
                failures++;
                $display("MISMATCH %0t read data %h", $time, rdat);
            end
        end
        if (cycles == 5000) begin
            failures++;
            give_verdict();
        end
    end
    initial begin
        void'($urandom(32'hCD20DB96));
        repeat (12) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        rd_chk(6'h30, 24'h400003);
        rd_chk(6'h31, 24'h000040);
        out_chk();
        host_u.access(1'b1, 6'h2F, 24'hFFFFFF);
        host_u.access(1'b1, 6'h2E, 24'hFFFFFF);
        rd_chk(6'h2F, 24'h000000);
        rd_chk(6'h2E, {15'h0000, GEN, 6'h00});
        rd_chk(6'h07, 24'h000000);
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            r1 = 10'($urandom);
            r2 = 10'($urandom);
            sload = 1'b1;
            @(negedge clk) sload = 1'b0;
            rd_chk(6'h2F, {r2, 2'h0, r1, 2'h0});
        end
        $display("reset and result tests done");
        for (int i = 0; i < 24; i++) begin
            d = 24'($urandom);
            d[20] = 1'b0;
            wr_chg(d);
            rd_chk(6'h30, chg_m);
            out_chk();
        end
        wr_chg(24'h100000);
        rd_chk(6'h30, chg_m);
        out_chk();
        @(negedge clk) done = 1'b1;
        @(negedge clk) done = 1'b0;
        chg_m[20] = 1'b0;
        rd_chk(6'h30, chg_m);
        out_chk();
        @(negedge clk);
        dval = 4'($urandom);
        dload = 1'b1;
        @(negedge clk) dload = 1'b0;
        chg_m[6:3] = dval;
        rd_chk(6'h30, chg_m);
        out_chk();
        for (int i = 0; i < 8; i++) begin
            d = 24'($urandom);
            host_u.access(1'b1, 6'h31, d);
            idpu_m = d[22];
            rd_chk(6'h31, d & 24'h400040);
            out_chk();
        end
        $display("control word tests done");
        // Reset in mid-run must bring back every default
        @(negedge clk) rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        chg_m = 24'h400003;
        idpu_m = 1'b0;
        rd_chk(6'h2F, 24'h000000);
        rd_chk(6'h30, chg_m);
        rd_chk(6'h31, 24'h000040);
        out_chk();
        $display("reset recovery test done");
        repeat (4) @(posedge clk);
        give_verdict();
    end
endmodule : test_acr_regs
